// File: logic/sac_ctrl.sv
// sar converter control: register slave, conversion and calibration control
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - converter clock is system clock over two over divider
// - sixteen converter cycles, converter clock at most 4MHz
// - only a software start bit write begins conversion
// - start bit reads back busy
// - end flag set on completion, blocks new starts
// - irq enable makes end flag raise interrupt
// - guard bit write touches only bits one, zero
// - calibration bit write starts stage, reads done
// - sensor select routes input to sensor or pins
// - bits seven and six enable the sensors
// - reference fields are plain storage only
// - twelve-bit result in low bits, rest zero
module sac_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog macro
  input wire logic [11:0] adc_data_in,
  output sac_ana_type ana,
  // interrupt
  output logic irq
);
  // whole state of the controller
  typedef struct packed {
    sac_fsm_type fsm;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    sac_cfg_type cfg;
    logic eoc;
    logic [2:0] cal_done;
    logic [1:0] cal_stage;
    logic [11:0] result;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } sac_regs_type;

  sac_regs_type s_r; // registered state
  sac_regs_type s_nxt; // next state

  // engine handshake
  logic eng_start; // begin a run this cycle
  logic [4:0] eng_len; // converter cycles of the run
  logic eng_tick; // one converter clock elapsed
  logic eng_busy; // run in progress
  logic eng_done; // run just finished

  // write decode helpers
  logic wr_do; // write applied this cycle
  logic [31:0] wr_word; // write data merged by byte strobes
  logic guard; // low-bits-only write
  logic start_req; // software start request
  logic eoc_clear; // software clears end flag
  logic [2:0] cal_req; // calibration stage requests
  logic [IRQ_W-1:0] irq_set; // events of this cycle
  logic [IRQ_W-1:0] irq_clr; // software clear of status bits

  // readback image of the configuration and status word
  function automatic logic [31:0] cfg_word(input sac_cfg_type c, input logic [2:0] cd,
                                           input logic e, input logic b);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[POS_ENABLE] = c.en;
    w[POS_CAL_C] = cd[2];
    w[POS_CAL_B] = cd[1];
    w[POS_CAL_A] = cd[0];
    w[POS_REF_SEL] = c.ref_source_select;
    w[POS_REF_LVL +: 9] = c.ref_level_setting;
    w[POS_DIV +: 8] = c.conv_clock_divider;
    w[POS_DIODE] = c.diode_sensor_enable;
    w[POS_BANDGAP] = c.bandgap_sensor_enable;
    w[POS_SENSOR] = c.sensor_input_select;
    w[POS_IRQ_EN] = c.irq_enable;
    w[POS_EOC] = e;
    w[POS_START] = b;
    return w;
  endfunction

  // keep unstrobed bytes at their old value
  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // true when an address hits a mapped register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CFG) || (a == OFS_RESULT) || (a == OFS_IRQ_STATUS) ||
           (a == OFS_IRQ_CLEAR) || (a == OFS_IRQ_ENABLE);
  endfunction

  // converter clock divider and cycle counter
  sac_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_r.cfg.en),
    .start(eng_start),
    .len(eng_len),
    .divider(s_r.cfg.conv_clock_divider),
    .tick(eng_tick),
    .busy(eng_busy),
    .done(eng_done)
  );

  // next-state logic for bus, registers and controller
  always_comb begin
    s_nxt = s_r;
    eng_start = 1'b0;
    eng_len = CONV_TICKS;
    irq_set = '0;
    irq_clr = '0;
    start_req = 1'b0;
    eoc_clear = 1'b0;
    cal_req = 3'b000;
    guard = 1'b0;
    wr_do = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_word = 32'h0000_0000;

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end

    // apply a complete write and answer it
    if (wr_do) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_mapped(s_r.waddr) ? RESP_OKAY : RESP_DECERR;
      case (s_r.waddr)
        OFS_CFG: begin
          wr_word = strb_merge(cfg_word(s_r.cfg, s_r.cal_done, s_r.eoc,
                                        s_r.fsm == ST_CONV), s_r.wdata, s_r.wstrb);
          guard = s_r.wstrb[0] && s_r.wdata[POS_GUARD];
          // low control bits act in both kinds of write
          start_req = s_r.wstrb[0] && s_r.wdata[POS_START];
          eoc_clear = s_r.wstrb[0] && !s_r.wdata[POS_EOC];
          if (!guard) begin
            // full write updates every field
            s_nxt.cfg.en = wr_word[POS_ENABLE];
            s_nxt.cfg.ref_source_select = wr_word[POS_REF_SEL];
            s_nxt.cfg.ref_level_setting = wr_word[POS_REF_LVL +: 9];
            s_nxt.cfg.conv_clock_divider = wr_word[POS_DIV +: 8];
            s_nxt.cfg.diode_sensor_enable = wr_word[POS_DIODE];
            s_nxt.cfg.bandgap_sensor_enable = wr_word[POS_BANDGAP];
            s_nxt.cfg.sensor_input_select = wr_word[POS_SENSOR];
            s_nxt.cfg.irq_enable = wr_word[POS_IRQ_EN];
            if (s_r.wstrb[3]) begin
              cal_req = {s_r.wdata[POS_CAL_C], s_r.wdata[POS_CAL_B],
                         s_r.wdata[POS_CAL_A]};
            end
          end else begin
            // guarded write leaves all upper fields alone
            s_nxt.cfg = s_r.cfg;
          end
        end
        OFS_IRQ_CLEAR: begin
          // ones clear status bits
          if (s_r.wstrb[0]) begin
            irq_clr = s_r.wdata[IRQ_W-1:0];
          end
        end
        OFS_IRQ_ENABLE: begin
          if (s_r.wstrb[0]) begin
            s_nxt.irq_mask = s_r.wdata[IRQ_W-1:0];
          end
        end
        default: begin
          // read-only or unmapped: no effect
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // read: data registered with the address handshake
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      case (s_axi_araddr)
        OFS_CFG: begin
          s_nxt.rdata = cfg_word(s_r.cfg, s_r.cal_done, s_r.eoc, s_r.fsm == ST_CONV);
        end
        OFS_RESULT: begin
          s_nxt.rdata = {20'h00000, s_r.result};
        end
        OFS_IRQ_STATUS: begin
          s_nxt.rdata = {{(32-IRQ_W){1'b0}}, s_r.irq_status};
        end
        OFS_IRQ_ENABLE: begin
          s_nxt.rdata = {{(32-IRQ_W){1'b0}}, s_r.irq_mask};
        end
        default: begin
          // write-only and unmapped words read zero
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // end flag: software clear, hardware set wins
    if (eoc_clear) begin
      s_nxt.eoc = 1'b0;
    end

    // controller sequence
    case (s_r.fsm)
      ST_IDLE: begin
        // a write that drops enable must not start anything
        if (s_r.cfg.en && s_nxt.cfg.en && start_req && !s_r.eoc) begin
          // start only when enabled and end flag is clear
          eng_start = 1'b1;
          eng_len = CONV_TICKS;
          s_nxt.fsm = ST_CONV;
        end else if (s_r.cfg.en && s_nxt.cfg.en && (cal_req != 3'b000)) begin
          // one stage at a time, lowest stage wins
          eng_start = 1'b1;
          eng_len = CAL_TICKS;
          s_nxt.fsm = ST_CAL;
          if (cal_req[0]) begin
            s_nxt.cal_stage = 2'h0;
          end else if (cal_req[1]) begin
            s_nxt.cal_stage = 2'h1;
          end else begin
            s_nxt.cal_stage = 2'h2;
          end
          s_nxt.cal_done[s_nxt.cal_stage] = 1'b0;
        end
      end
      ST_CONV: begin
        // further starts are ignored while busy
        // new enable value, so busy drops with the disabling write
        if (!s_nxt.cfg.en) begin
          s_nxt.fsm = ST_IDLE;
        end else if (eng_done) begin
          s_nxt.fsm = ST_IDLE;
          s_nxt.result = adc_data_in;
          s_nxt.eoc = 1'b1;
          irq_set[IRQ_EOC] = 1'b1;
        end
      end
      ST_CAL: begin
        if (!s_nxt.cfg.en) begin
          s_nxt.fsm = ST_IDLE;
        end else if (eng_done) begin
          s_nxt.fsm = ST_IDLE;
          s_nxt.cal_done[s_r.cal_stage] = 1'b1;
          irq_set[IRQ_CAL] = 1'b1;
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase

    // disabling drops calibration results
    if (!s_nxt.cfg.en) begin
      s_nxt.cal_done = 3'b000;
    end

    // sticky status, set wins over clear
    s_nxt.irq_status = (s_r.irq_status & ~irq_clr) | irq_set;
    // end flag with its enable, plus masked status
    s_nxt.irq = (s_nxt.eoc && s_nxt.cfg.irq_enable) ||
                ((s_nxt.irq_status & s_nxt.irq_mask) != '0);
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.cfg.conv_clock_divider <= DIV_RESET;
      s_r.cfg.ref_level_setting <= REF_LVL_RESET;
      s_r.result <= RESULT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // bus handshakes
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

  // analog controls from the stored fields
  assign ana.converter_enable = s_r.cfg.en;
  assign ana.sensor_input_select = s_r.cfg.sensor_input_select;
  assign ana.diode_sensor_enable = s_r.cfg.diode_sensor_enable;
  assign ana.bandgap_sensor_enable = s_r.cfg.bandgap_sensor_enable;
  // last tick comes with done; hide the tail of an aborted run
  assign ana.conv_tick = eng_tick && (s_r.fsm != ST_IDLE);
  assign ana.converting = (s_r.fsm == ST_CONV) && (eng_busy || eng_done);
  assign ana.calibrating = (s_r.fsm == ST_CAL) && (eng_busy || eng_done);
  assign ana.cal_stage = s_r.cal_stage;

  // interrupt level
  assign irq = s_r.irq;
endmodule

// File: logic/sac_pkg.sv
// shared constants and types of the sar converter control block
package sac_pkg;
  // system clock and converter clock limit
  localparam int unsigned SYS_CLK_HZ = 250_000_000;
  localparam int unsigned CONV_CLK_MAX_HZ = 4_000_000;
  // smallest divider that keeps the converter clock at or below its limit
  localparam int unsigned DIV_MIN_INT = (SYS_CLK_HZ + 2 * CONV_CLK_MAX_HZ - 1) /
                                        (2 * CONV_CLK_MAX_HZ);
  localparam logic [7:0] DIV_MIN = 8'(DIV_MIN_INT);
  // converter clock cycles per conversion and per calibration stage
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [4:0] CAL_TICKS = 5'h10;
  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // field positions of the configuration and status word
  localparam int unsigned POS_ENABLE = 31;
  localparam int unsigned POS_CAL_C = 28;
  localparam int unsigned POS_CAL_B = 27;
  localparam int unsigned POS_CAL_A = 26;
  localparam int unsigned POS_REF_SEL = 25;
  localparam int unsigned POS_REF_LVL = 16;
  localparam int unsigned POS_DIV = 8;
  localparam int unsigned POS_DIODE = 7;
  localparam int unsigned POS_BANDGAP = 6;
  localparam int unsigned POS_SENSOR = 5;
  localparam int unsigned POS_IRQ_EN = 4;
  localparam int unsigned POS_GUARD = 2;
  localparam int unsigned POS_EOC = 1;
  localparam int unsigned POS_START = 0;
  // interrupt status layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_EOC = 0;
  localparam int unsigned IRQ_CAL = 1;
  // values after reset
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [8:0] REF_LVL_RESET = 9'h000;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CAL = 3'b100
  } sac_fsm_type;
  // software fields of the configuration word
  typedef struct packed {
    logic en;
    logic ref_source_select;
    logic [8:0] ref_level_setting;
    logic [7:0] conv_clock_divider;
    logic diode_sensor_enable;
    logic bandgap_sensor_enable;
    logic sensor_input_select;
    logic irq_enable;
  } sac_cfg_type;
  // controls toward the analog macro
  typedef struct packed {
    logic converter_enable;
    logic sensor_input_select;
    logic diode_sensor_enable;
    logic bandgap_sensor_enable;
    logic conv_tick;
    logic converting;
    logic calibrating;
    logic [1:0] cal_stage;
  } sac_ana_type;
endpackage

// File: logic/sac_engine.sv
// converter clock divider and cycle counter for conversions and calibration
`timescale 1ns/1ps
module sac_engine
  import sac_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic start,
  input wire logic [4:0] len,
  input wire logic [7:0] divider,
  // status
  output logic tick,
  output logic busy,
  output logic done
);
  // engine state
  typedef struct packed {
    logic [8:0] pre;
    logic [4:0] left;
    logic busy;
    logic tick;
    logic done;
  } sac_eng_type;

  sac_eng_type s_r; // registered state
  sac_eng_type s_nxt; // next state
  logic [7:0] div_eff; // divider after clamping
  logic [8:0] period; // system clocks per converter clock

  // clamp the divider so the converter clock never runs too fast
  always_comb begin
    div_eff = (divider < DIV_MIN) ? DIV_MIN : divider;
    period = {div_eff, 1'b0};
  end

  // prescaler and converter-cycle counter
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.done = 1'b0;
    if (!run) begin
      // disabled: abort and hold idle
      s_nxt.busy = 1'b0;
      s_nxt.pre = 9'h000;
      s_nxt.left = 5'h00;
    end else if (start && !s_r.busy) begin
      // begin a new run of len converter cycles
      s_nxt.busy = 1'b1;
      s_nxt.pre = 9'h000;
      s_nxt.left = len;
    end else if (s_r.busy) begin
      if (s_r.pre == period - 9'h001) begin
        // one converter clock period elapsed
        s_nxt.pre = 9'h000;
        s_nxt.tick = 1'b1;
        s_nxt.left = s_r.left - 5'h01;
        if (s_r.left == 5'h01) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end else begin
        s_nxt.pre = s_r.pre + 9'h001;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
  assign busy = s_r.busy;
  assign done = s_r.done;
endmodule

// File: testbench/sac_monitor.sv
// port checker for the sar converter control block
`timescale 1ns/1ps
module sac_monitor
  import sac_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog controls
  input sac_ana_type ana
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_conv_enabled: assert property (ana.converting |-> ana.converter_enable)
    else $error("conversion runs while disabled");
  chk_tick_spacing: assert property (ana.conv_tick |=> !ana.conv_tick [*8])
    else $error("converter clock too fast");
  chk_tick_running: assert property (ana.conv_tick |-> ana.converting || ana.calibrating)
    else $error("converter clock outside operation");
endmodule
bind sac_ctrl sac_monitor u_sac_monitor (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ana(ana));

// File: testbench/sac_ctrl_tb.sv
// self-checking bench for the sar converter control block
`timescale 1ns/1ps
module sac_ctrl_tb
  import sac_pkg::*;
;
  localparam int DIV = 40;
  localparam logic [31:0] CFG_A = 32'h82ab_28f0; // enable, ref fields, divider 40, bits 7..4
  // value the analog macro hands back for every conversion
  localparam logic [11:0] ADC_VAL = 12'h5a3;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  sac_ana_type ana;
  int fail_count = 0;
  int checks = 0;
  int ticks = 0; // converter clock pulses seen
  bit slow = 1'b0; // late ready on the answer channels
  sac_ctrl u_sac_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .adc_data_in(ADC_VAL), .ana(ana), .irq(irq));
  // 250 mhz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // count converter clock pulses
  always @(posedge aclk) ticks <= ticks + int'(ana.conv_tick);
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a bounded wait ran out
  task automatic hang();
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    close_out();
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus write, response into resp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
  endtask
  // one bus read, data into rdat
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
  endtask
  // reset values, unmapped place, start while disabled
  task automatic t_reset();
    chk(32'(ana), 32'h0);
    rd(OFS_CFG);
    chk(rdat, 32'h0);
    rd(OFS_RESULT);
    chk(rdat, 32'h0);
    rd(8'h40);
    chk(rdat, 32'h0);
    chk(32'(resp), 32'(RESP_DECERR));
    wr(8'h40, 32'hffff_ffff, 4'hf);
    chk(32'(resp), 32'(RESP_DECERR));
    wr(OFS_CFG, 32'h0000_0001, 4'h1);
    rd(OFS_CFG);
    chk(rdat, 32'h0);
    chk(32'(ana.converting), 32'h0);
    $display("test reset done");
  endtask
  // fields stored and routed, answers taken late
  task automatic t_config();
    slow = 1'b1;
    wr(OFS_CFG, CFG_A, 4'hf);
    rd(OFS_CFG);
    slow = 1'b0;
    chk(rdat, CFG_A);
    chk(32'(ana), 32'h1e0);
    $display("test config done");
  endtask
  // guarded start, restart while busy, divider, end flag
  task automatic t_convert();
    int n;
    int g;
    int t0;
    t0 = ticks;
    wr(OFS_CFG, 32'h0000_0005, 4'hf);
    rd(OFS_CFG);
    chk(rdat, CFG_A | 32'h1);
    wr(OFS_CFG, 32'h0000_0005, 4'hf);
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (ana.conv_tick) break;
    end
    for (g = 1; g < 300; g++) begin
      @(posedge aclk);
      if (ana.conv_tick) break;
    end
    if (n == 300 || g == 300) hang();
    chk(32'(g), 32'(2 * DIV));
    for (n = 0; n < 1000; n++) begin
      rd(OFS_CFG);
      if (rdat[POS_EOC]) break;
    end
    if (n == 1000) hang();
    chk(rdat, CFG_A | 32'h2);
    chk(32'(ticks - t0), 32'd16);
    rd(OFS_RESULT);
    chk(rdat, {20'h0, ADC_VAL});
    chk(32'(irq), 32'h1);
    wr(OFS_CFG, 32'h0000_0007, 4'hf);
    rd(OFS_CFG);
    chk(rdat, CFG_A | 32'h2);
    wr(OFS_CFG, 32'h0000_0004, 4'hf);
    rd(OFS_CFG);
    chk(rdat, CFG_A);
    chk(32'(irq), 32'h0);
    $display("test convert done");
  endtask
  // sticky status raised, masked and cleared
  task automatic t_irq();
    rd(OFS_IRQ_STATUS);
    chk(rdat, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h1, 4'h1);
    rd(OFS_IRQ_ENABLE);
    chk(rdat, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0, 4'h1);
    rd(OFS_IRQ_CLEAR);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h1, 4'h1);
    wr(OFS_IRQ_ENABLE, 32'h1, 4'h1);
    rd(OFS_IRQ_STATUS);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test irq done");
  endtask
  // calibration stages a, b, c in turn
  task automatic t_calib();
    int i;
    int n;
    for (i = 0; i < 3; i++) begin
      wr(OFS_CFG, CFG_A | (32'h1 << (POS_CAL_A + i)), 4'h8);
      chk(32'(ana.cal_stage), 32'(i));
      for (n = 0; n < 2000; n++) begin
        @(posedge aclk);
        if (!ana.calibrating) break;
      end
      if (n == 2000) hang();
      rd(OFS_CFG);
      chk(32'(rdat[POS_CAL_A + i]), 32'h1);
    end
    rd(OFS_IRQ_STATUS);
    chk(rdat, 32'h2);
    $display("test calib done");
  endtask
  // converter turned off in mid conversion
  task automatic t_disable();
    wr(OFS_CFG, 32'h0000_0005, 4'hf);
    rd(OFS_CFG);
    chk(rdat, CFG_A | 32'h1c00_0001);
    wr(OFS_CFG, 32'h0, 4'hf);
    rd(OFS_CFG);
    chk(rdat, 32'h0);
    chk(32'(ana), 32'h2);
    repeat (1400) @(posedge aclk);
    rd(OFS_CFG);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test disable done");
  endtask
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_config();
    t_convert();
    t_irq();
    t_calib();
    t_disable();
    close_out();
  end
endmodule
